/* hw/mrat_ctrl.sv */
// Controller end: paces register reads and writes against command spacing
// Operation
// RQ1: Register write allowed idle or active
// RQ2: Register access returns to prior bank state
// RQ3: Register read to write spacing, no termination
// RQ4: Register read to write spacing, termination on
// RQ5: Register read to register write spacing
// RQ6: Write to register read spacing
// RQ7: Power-down exit to register read wait
// RQ8: Read to register write spacing
// RQ9: Auto-precharge read adds precharge cycles minus eight
// RQ10: Write to register write spacing
// RQ11: Auto-precharge write adds write recovery
// RQ12: Boost bit one enables high current
// RQ13: High current active within 200 ns
// RQ14: Only deselect during boost settle time
// RQ15: Boost bit zero restores normal current
// RQ16: High current off within 100 ns
// RQ17: Vref changes accepted without boost
// RQ18: Readback burst sixteen, value in first four
// RQ19: Register writes spaced by write period
// RQ20: Writes to read-only registers ignored
// RQ21: Register write to command delay
// RQ22: Register read period before next read
`timescale 1ns/1ps
`default_nettype none
module mrat_ctrl (
    input  wire logic                   clock,
    input  wire logic                   rstn,
    mrat_if.ctrl                        bus,
    input  wire logic                   req_valid,
    input  wire mrat_pkg::mrat_cmd_t    req_cmd,
    input  wire logic [mrat_pkg::MA_W-1:0]   req_ma,
    input  wire logic [mrat_pkg::DATA_W-1:0] req_op,
    input  wire logic                   odt_enable,
    output logic                        req_ready,
    output logic [mrat_pkg::DATA_W-1:0] rd_data,
    output logic                        rd_data_valid
);
    import mrat_pkg::*;

    typedef enum logic {C_IDLE, C_WAIT} mrat_cst_t;

    mrat_cst_t         st_r;
    mrat_cst_t         st_nxt;
    mrat_cmd_t         pend_r;
    logic [MA_W-1:0]   pma_r;
    logic [DATA_W-1:0] pop_r;
    logic              podt_r;
    mrat_cmd_t         cmd_r;
    logic [MA_W-1:0]   ma_r;
    logic [DATA_W-1:0] op_r;
    logic              ready_r;
    logic [CNT_W-1:0]  cnt_r [NCL];
    logic [CNT_W-1:0]  sp [NCL];
    logic [CNT_W-1:0]  all_r;
    logic              oe_d_r;
    logic [DATA_W-1:0] rdd_r;
    logic              rdv_r;

    // Decode of the held request
    wire logic p_mrr = pend_r == CMD_MRR;
    wire logic p_mrw = pend_r == CMD_MRW;
    wire logic p_pdx = pend_r == CMD_PDX;
    wire logic p_rda = pend_r == CMD_RDA;
    wire logic p_rd = (pend_r == CMD_RD) || (pend_r == CMD_RDFIFO) || (pend_r == CMD_RDCAL);
    wire logic p_wra = (pend_r == CMD_WRA) || (pend_r == CMD_MWRA);
    wire logic p_wr = (pend_r == CMD_WR) || (pend_r == CMD_MWR) || (pend_r == CMD_WRFIFO);
    wire logic p_rdcol = (pend_r == CMD_RD) || p_rda;
    wire logic p_wrcol = (pend_r == CMD_WR) || (pend_r == CMD_MWR) || p_wra;

    // Spacing each target class must keep after the held command
    assign sp[CL_MRR] = p_mrr ? G_MRR : // RQ22
                        p_mrw ? G_MRD : // RQ21
                        (p_rd || p_rda) ? G_RD_MRR :
                        (p_wr || p_wra) ? G_WR_MRR : // RQ6
                        p_pdx ? G_PDX_MRR : '0; // RQ7
    assign sp[CL_MRW] = p_mrr ? G_MRR_MRW : // RQ5
                        p_mrw ? G_MRW : // RQ19
                        p_rda ? G_RDA_MRW : // RQ9
                        p_rd ? G_RD_MRW : // RQ8
                        p_wra ? G_WRA_MRW : // RQ11
                        p_wr ? G_WR_MRW : '0; // RQ10
    assign sp[CL_RD] = p_mrr ? G_MRR : // RQ22
                       p_mrw ? G_MRD : '0; // RQ21
    assign sp[CL_WR] = p_mrr ? (podt_r ? G_MRR_WR_ODT : G_MRR_WR) : // RQ3 RQ4
                       p_mrw ? G_MRD : '0; // RQ21

    // Banks may be open or idle
    wire logic cls_busy = p_mrr ? (cnt_r[CL_MRR] != '0) :
                          p_mrw ? (cnt_r[CL_MRW] != '0) : // RQ1
                          p_rdcol ? (cnt_r[CL_RD] != '0) :
                          p_wrcol ? (cnt_r[CL_WR] != '0) : 1'b0;
    // Boost settle blocks everything, so only deselect goes out
    wire logic issue = (st_r == C_WAIT) && !cls_busy && (all_r == '0); // RQ14
    wire logic hit_boost = issue && p_mrw && (pma_r == MR_BOOST);
    wire logic [CNT_W-1:0] all_ld = pop_r[BOOST_BIT] ? G_BOOST_ON : G_BOOST_OFF; // RQ14
    wire logic [CNT_W-1:0] all_dec = (all_r != '0) ? (all_r - CNT_ONE) : '0;
    wire logic rd_first = bus.dq_oe && !oe_d_r; // RQ18

    // Counters only ever lengthen: a new load never cuts a longer wait
    for (genvar c = 0; c < NCL; c++) begin : g_cnt
        wire logic [CNT_W-1:0] dec = (cnt_r[c] != '0) ? (cnt_r[c] - CNT_ONE) : '0;
        wire logic [CNT_W-1:0] nxt = (issue && sp[c] > dec) ? sp[c] : dec;
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                cnt_r[c] <= '0;
            end else begin
                cnt_r[c] <= nxt;
            end
        end
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            C_IDLE: begin
                if (req_valid && ready_r) begin
                    st_nxt = C_WAIT;
                end
            end
            C_WAIT: begin
                if (issue) begin
                    st_nxt = C_IDLE;
                end
            end
            default: begin
                st_nxt = C_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= C_IDLE;
            ready_r <= 1'b0;
            all_r <= '0;
        end else begin
            st_r <= st_nxt;
            ready_r <= st_nxt == C_IDLE;
            all_r <= hit_boost ? all_ld : all_dec; // RQ14
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend_r <= CMD_DES;
            pma_r <= '0;
            pop_r <= '0;
            podt_r <= 1'b0;
        end else if (st_r == C_IDLE && req_valid && ready_r) begin
            pend_r <= req_cmd;
            pma_r <= req_ma;
            pop_r <= req_op;
            podt_r <= odt_enable;
        end
    end

    // Deselect fills every cycle that carries no command
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmd_r <= CMD_DES;
            ma_r <= '0;
            op_r <= '0;
        end else if (issue) begin
            cmd_r <= pend_r;
            ma_r <= pma_r;
            op_r <= pop_r;
        end else begin
            cmd_r <= CMD_DES;
        end
    end

    // Readback value is taken on the first beat only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            oe_d_r <= 1'b0;
            rdd_r <= '0;
            rdv_r <= 1'b0;
        end else begin
            oe_d_r <= bus.dq_oe;
            rdd_r <= rd_first ? bus.dq : rdd_r;
            rdv_r <= rd_first;
        end
    end

    assign bus.cmd = cmd_r;
    assign bus.ma = ma_r;
    assign bus.op = op_r;
    assign req_ready = ready_r;
    assign rd_data = rdd_r;
    assign rd_data_valid = rdv_r;
endmodule
`default_nettype wire

/* hw/mrat_dev.sv */
// DRAM channel end: bank state, mode registers, readback burst, boost
`timescale 1ns/1ps
`default_nettype none
module mrat_dev (
    input  wire logic                   clock,
    input  wire logic                   rstn,
    mrat_if.dev                         bus,
    output logic                        vref_current_boost,
    output logic [mrat_pkg::VREF_W-1:0] vref_ca_setting,
    output logic [mrat_pkg::VREF_W-1:0] vref_dq_setting,
    output logic [mrat_pkg::BANKS-1:0]  bank_open,
    output mrat_pkg::mrat_state_t       access_state
);
    import mrat_pkg::*;

    logic [DATA_W-1:0] mr_r [NUM_MR];
    logic [DATA_W-1:0] rdd_r [RL];
    logic [RL-1:0]     rdv_r;
    logic [BANKS-1:0]  bank_r;
    mrat_state_t       st_r;
    logic [CNT_W-1:0]  beat_r;
    logic [DATA_W-1:0] val_r;
    logic [DATA_W-1:0] dq_r;
    logic              oe_r;
    logic              tgt_r;
    logic              pend_r;
    logic              boost_r;
    logic [CNT_W-1:0]  settle_r;
    logic [VREF_W-1:0] ca_r;
    logic [VREF_W-1:0] vdq_r;

    wire logic is_mrr = bus.cmd == CMD_MRR;
    wire logic is_mrw = bus.cmd == CMD_MRW;
    wire logic wr_ok = is_mrw && !RO_MASK[bus.ma]; // RQ20
    wire logic hit_boost = wr_ok && (bus.ma == MR_BOOST);
    wire logic [BANKS-1:0] sel = BANK_ONE << bus.ma[BA_W-1:0];
    // Register accesses leave the open-row set untouched
    wire logic [BANKS-1:0] bank_nxt = (bus.cmd == CMD_ACT) ? (bank_r | sel) :
                                      (bus.cmd == CMD_PRE) ? (bank_r & ~sel) : bank_r; // RQ2
    wire mrat_state_t st_nxt = is_mrr ? ST_MRR : is_mrw ? ST_MRW : // RQ1
                               (|bank_nxt) ? ST_ACTIVE : ST_IDLE; // RQ2
    wire logic start = rdv_r[RL-1];
    wire logic more = oe_r && (beat_r != LAST_BEAT);
    wire logic [CNT_W-1:0] beat_inc = beat_r + CNT_ONE;
    // Value repeats over the first four bit times, rest reads zero
    wire logic [DATA_W-1:0] dq_nxt = start ? rdd_r[RL-1] :
                                     (more && beat_inc < VALUE_BEATS) ? val_r : '0; // RQ18
    wire logic [CNT_W-1:0] settle_ld = bus.op[BOOST_BIT] ? D_BOOST_ON : D_BOOST_OFF; // RQ13 RQ16

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_MR; i++) begin
                mr_r[i] <= '0;
            end
        end else if (wr_ok) begin
            mr_r[bus.ma] <= bus.op;
        end
    end

    // Read latency line
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdv_r <= '0;
            rdd_r[0] <= '0;
        end else begin
            rdv_r <= {rdv_r[RL-2:0], is_mrr};
            rdd_r[0] <= mr_r[bus.ma];
        end
    end
    for (genvar i = 1; i < RL; i++) begin : g_rl
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                rdd_r[i] <= '0;
            end else begin
                rdd_r[i] <= rdd_r[i-1];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            beat_r <= '0;
            val_r <= '0;
            dq_r <= '0;
            oe_r <= 1'b0;
        end else begin
            beat_r <= start ? '0 : beat_inc;
            val_r <= start ? rdd_r[RL-1] : val_r;
            dq_r <= dq_nxt; // RQ18
            oe_r <= start | more; // RQ18
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bank_r <= '0;
            st_r <= ST_IDLE;
        end else begin
            bank_r <= bank_nxt;
            st_r <= st_nxt;
        end
    end

    // Vref taken whatever the boost state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ca_r <= '0;
            vdq_r <= '0;
        end else if (wr_ok && bus.ma == MR_VREF_CA) begin
            ca_r <= bus.op[VREF_W-1:0]; // RQ17
        end else if (wr_ok && bus.ma == MR_VREF_DQ) begin
            vdq_r <= bus.op[VREF_W-1:0]; // RQ17
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tgt_r <= 1'b0;
            pend_r <= 1'b0;
            boost_r <= 1'b0;
            settle_r <= '0;
        end else if (hit_boost) begin
            tgt_r <= bus.op[BOOST_BIT]; // RQ12 RQ15
            pend_r <= 1'b1;
            settle_r <= settle_ld;
        end else if (pend_r && settle_r == '0) begin
            boost_r <= tgt_r; // RQ12 RQ15
            pend_r <= 1'b0;
        end else if (pend_r) begin
            settle_r <= settle_r - CNT_ONE;
        end
    end

    assign bus.dq = dq_r;
    assign bus.dq_oe = oe_r;
    assign vref_current_boost = boost_r;
    assign vref_ca_setting = ca_r;
    assign vref_dq_setting = vdq_r;
    assign bank_open = bank_r;
    assign access_state = st_r;
endmodule
`default_nettype wire

/* hw/mrat_if.sv */
// Command and data link between controller and DRAM channel
`timescale 1ns/1ps
`default_nettype none
interface mrat_if;
    import mrat_pkg::*;
    mrat_cmd_t           cmd;
    logic [MA_W-1:0]     ma;
    logic [DATA_W-1:0]   op;
    logic [DATA_W-1:0]   dq;
    logic                dq_oe;
    modport ctrl (output cmd, output ma, output op, input dq, input dq_oe);
    modport dev  (input cmd, input ma, input op, output dq, output dq_oe);
endinterface
`default_nettype wire

/* hw/mrat_none.sv */
// Holds no logic

/* hw/mrat_pkg.sv */
// Shared types, constants and spacing figures for mode-register access timing
package mrat_pkg;
    typedef enum logic [3:0] {
        CMD_DES, CMD_MRR, CMD_MRW, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_MWR,
        CMD_MWRA, CMD_RDFIFO, CMD_RDCAL, CMD_WRFIFO, CMD_ACT, CMD_PRE, CMD_PDX
    } mrat_cmd_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_MRR, ST_MRW} mrat_state_t;

    localparam int MA_W   = 6;
    localparam int DATA_W = 8;
    localparam int BANKS  = 8;
    localparam int BA_W   = 3;
    localparam int NUM_MR = 64;
    localparam int CNT_W  = 8;
    localparam int VREF_W = 7;
    localparam int NCL    = 4;
    localparam int CL_MRR = 0;
    localparam int CL_MRW = 1;
    localparam int CL_RD  = 2;
    localparam int CL_WR  = 3;

    // Figures in cycles unless named ps or ns
    localparam int CLK_PS       = 20000;
    localparam int RL           = 14;
    localparam int WL           = 8;
    localparam int BL           = 16;
    localparam int HALF_BL      = BL / 2;
    localparam int WPRE         = 2;
    localparam int TERMINATION_ON_LATENCY       = 4;
    localparam int DQSCK_MAX_PS = 3600;
    localparam int RPST_PS      = 10000;
    localparam int ODTON_MIN_PS = 1500;
    localparam int WTR_PS       = 10000;
    localparam int GAP_PS       = 7500;
    localparam int GAP_MIN_NCK  = 8;
    localparam int READ_TO_PRECHARGE_CYCLES         = 8;
    localparam int WRITE_RECOVERY_CYCLES          = 6;
    localparam int TMRR         = 8;
    localparam int REGWRITE_TO_CMD_DELAY         = 10;
    localparam int TMRW         = 10;
    localparam int TXP          = 5;
    localparam int PD_EXIT_READBACK_WAIT        = 4;
    localparam int BOOST_ON_NS  = 200;
    localparam int BOOST_OFF_NS = 100;

    function automatic int ru(input int ps);
        return (ps + CLK_PS - 1) / CLK_PS;
    endfunction
    function automatic int rd(input int ps);
        return ps / CLK_PS;
    endfunction
    function automatic int maxi(input int a, input int b);
        return (a > b) ? a : b;
    endfunction
    // Spacing n becomes a countdown load of n-1
    function automatic logic [CNT_W-1:0] gap(input int n);
        return (n > 1) ? CNT_W'(n - 1) : '0;
    endfunction

    localparam int DQSCK = ru(DQSCK_MAX_PS);
    localparam int GAP8  = maxi(ru(GAP_PS), GAP_MIN_NCK);
    localparam int SP_MRR_WR     = RL + DQSCK + HALF_BL - WL + WPRE + rd(RPST_PS);
    localparam int SP_MRR_WR_ODT = RL + DQSCK + HALF_BL - TERMINATION_ON_LATENCY - rd(ODTON_MIN_PS)
                                   + rd(RPST_PS) + 1;
    localparam int SP_MRR_MRW    = RL + DQSCK + HALF_BL + 3;
    localparam int SP_WR_MRR     = WL + 1 + HALF_BL + ru(WTR_PS);
    localparam int SP_RD_MRW     = RL + HALF_BL + DQSCK + rd(RPST_PS) + GAP8;
    localparam int SP_WR_MRW     = WL + 1 + HALF_BL + GAP8;

    localparam logic [CNT_W-1:0] G_MRR_WR     = gap(SP_MRR_WR);
    localparam logic [CNT_W-1:0] G_MRR_WR_ODT = gap(SP_MRR_WR_ODT);
    localparam logic [CNT_W-1:0] G_MRR_MRW    = gap(SP_MRR_MRW);
    localparam logic [CNT_W-1:0] G_MRR        = gap(TMRR);
    localparam logic [CNT_W-1:0] G_RD_MRR     = gap(HALF_BL);
    localparam logic [CNT_W-1:0] G_WR_MRR     = gap(SP_WR_MRR);
    localparam logic [CNT_W-1:0] G_PDX_MRR    = gap(TXP + PD_EXIT_READBACK_WAIT);
    localparam logic [CNT_W-1:0] G_MRD        = gap(REGWRITE_TO_CMD_DELAY);
    localparam logic [CNT_W-1:0] G_MRW        = gap(TMRW);
    localparam logic [CNT_W-1:0] G_RD_MRW     = gap(SP_RD_MRW);
    localparam logic [CNT_W-1:0] G_RDA_MRW    = gap(SP_RD_MRW + READ_TO_PRECHARGE_CYCLES - 8);
    localparam logic [CNT_W-1:0] G_WR_MRW     = gap(SP_WR_MRW);
    localparam logic [CNT_W-1:0] G_WRA_MRW    = gap(SP_WR_MRW + WRITE_RECOVERY_CYCLES);
    // Controller waits the full figure, rounded up
    localparam logic [CNT_W-1:0] G_BOOST_ON   = gap(ru(BOOST_ON_NS * 1000));
    localparam logic [CNT_W-1:0] G_BOOST_OFF  = gap(ru(BOOST_OFF_NS * 1000));
    // Device settles inside the figure, rounded down
    localparam logic [CNT_W-1:0] D_BOOST_ON   = gap(maxi(rd(BOOST_ON_NS * 1000), 1));
    localparam logic [CNT_W-1:0] D_BOOST_OFF  = gap(maxi(rd(BOOST_OFF_NS * 1000), 1));

    localparam logic [MA_W-1:0]    MR_VREF_CA  = 6'h0C;
    localparam logic [MA_W-1:0]    MR_BOOST    = 6'h0D;
    localparam logic [MA_W-1:0]    MR_VREF_DQ  = 6'h0E;
    localparam int                 BOOST_BIT   = 3;
    localparam logic [NUM_MR-1:0]  RO_MASK     = 64'h0000_0000_0000_01F1;
    localparam logic [BANKS-1:0]   BANK_ONE    = 8'h01;
    localparam logic [CNT_W-1:0]   CNT_ONE     = 8'h01;
    localparam logic [CNT_W-1:0]   LAST_BEAT   = 8'h07;
    localparam logic [CNT_W-1:0]   VALUE_BEATS = 8'h02;
endpackage

/* testbench/mode_register_access_timing_tb.sv */
// Bench joining controller and DRAM ends: spacing table, readback, boost
`timescale 1ns/1ps
`default_nettype none
module mode_register_access_timing_tb;
    import mrat_pkg::*;
    import mrat_tb_pkg::*;
    logic              clock;
    logic              rstn;
    logic              req_valid;
    logic              odt_enable;
    logic              req_ready;
    logic              rd_data_valid;
    logic              vref_current_boost;
    mrat_cmd_t         req_cmd;
    mrat_cmd_t         seen_r;
    mrat_state_t       access_state;
    logic [MA_W-1:0]   req_ma;
    logic [DATA_W-1:0] req_op;
    logic [DATA_W-1:0] rd_data;
    logic [VREF_W-1:0] vref_ca_setting;
    logic [VREF_W-1:0] vref_dq_setting;
    logic [BANKS-1:0]  bank_open;
    int                err_count = 0;
    int                tests_run = 0;
    int                cyc = 0;
    int                last_t = 0;
    int                prev_t = 0;
    int                n_issued = 0;

    mrat_if mrat_if_i ();
    mrat_ctrl mrat_ctrl_i (.clock(clock), .rstn(rstn), .bus(mrat_if_i.ctrl),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_ma(req_ma), .req_op(req_op),
        .odt_enable(odt_enable), .req_ready(req_ready), .rd_data(rd_data),
        .rd_data_valid(rd_data_valid));
    mrat_dev mrat_dev_i (.clock(clock), .rstn(rstn), .bus(mrat_if_i.dev),
        .vref_current_boost(vref_current_boost), .vref_ca_setting(vref_ca_setting),
        .vref_dq_setting(vref_dq_setting), .bank_open(bank_open), .access_state(access_state));
    mrat_chk mrat_chk_i (.clock(clock), .rstn(rstn), .cmd(mrat_if_i.cmd), .ma(mrat_if_i.ma),
        .op(mrat_if_i.op), .dq(mrat_if_i.dq), .dq_oe(mrat_if_i.dq_oe));

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_in(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("CHECK FAILED at %0t: cycles %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    // Issue times noted mid-cycle
    always @(negedge clock) begin
        cyc = cyc + 1;
        if (seen_r == CMD_MRR) check_eq(8'(access_state), 8'(ST_MRR));
        if (seen_r == CMD_MRW) check_eq(8'(access_state), 8'(ST_MRW));
        if (mrat_if_i.cmd != CMD_DES) begin
            prev_t <= last_t;
            last_t <= cyc;
            n_issued <= n_issued + 1;
        end
        seen_r = mrat_if_i.cmd;
    end

    task automatic issue(input mrat_cmd_t c, input logic [MA_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        @(negedge clock);
        req_valid = 1'b1;
        req_cmd = c;
        req_ma = a;
        req_op = d;
        for (k = 0; req_ready !== 1'b1 && k < 200; k++) @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
    endtask

    task automatic pair(input mrat_cmd_t a, input mrat_cmd_t b, input int n, input logic odt = 1'b0,
                        input logic [MA_W-1:0] am = MR_VREF_CA, input logic [DATA_W-1:0] d = 8'h00);
        int n0, k;
        n0 = n_issued;
        odt_enable = odt;
        issue(a, am, d);
        issue(b, MR_VREF_CA, 8'h00);
        for (k = 0; n_issued < n0 + 2 && k < 100; k++) @(negedge clock);
        check_in(last_t - prev_t, n, n + 2);
        // Let every spacing run out
        repeat (40) @(negedge clock);
    endtask

    task automatic readback(input logic [MA_W-1:0] a, input logic [DATA_W-1:0] exp);
        int k;
        issue(CMD_MRR, a, 8'h00);
        for (k = 0; rd_data_valid !== 1'b1 && k < 60; k++) @(negedge clock);
        check_eq({7'h00, rd_data_valid}, 8'h01);
        check_eq(rd_data, exp);
        repeat (30) @(negedge clock);
    endtask

    task automatic boost_time(input logic [DATA_W-1:0] d, input logic lvl, input int lim);
        int n0, k;
        check_eq({7'h00, vref_current_boost}, {7'h00, ~lvl});
        n0 = n_issued;
        issue(CMD_MRW, MR_BOOST, d);
        for (k = 0; n_issued == n0 && k < 50; k++) @(negedge clock);
        // Counted from the edge the device takes the write
        for (k = 0; vref_current_boost !== lvl && k < 20; k++) @(negedge clock);
        check_in(k, 1, lim);
        repeat (20) @(negedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // About ten times the expected run
    initial begin
        #(20 * 20000);
        err_count++;
        end_sim();
    end

    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_cmd = CMD_DES;
        req_ma = '0;
        req_op = '0;
        odt_enable = 1'b0;
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        issue(CMD_MRW, MR_VREF_CA, 8'h35);
        readback(MR_VREF_CA, 8'h35);
        check_eq({1'b0, vref_ca_setting}, 8'h35);
        check_eq(8'(access_state), 8'(ST_IDLE));
        issue(CMD_MRW, MR_VREF_DQ, 8'h5A);
        repeat (5) @(negedge clock);
        check_eq({1'b0, vref_dq_setting}, 8'h5A);
        issue(CMD_MRW, 6'h00, 8'hA5);
        readback(6'h00, 8'h00);
        issue(CMD_ACT, 6'h03, 8'h00);
        issue(CMD_MRW, MR_VREF_CA, 8'h21);
        readback(MR_VREF_CA, 8'h21);
        check_eq(bank_open, 8'h08);
        check_eq(8'(access_state), 8'(ST_ACTIVE));
        issue(CMD_PRE, 6'h03, 8'h00);
        repeat (4) @(negedge clock);
        check_eq(bank_open, 8'h00);
        boost_time(8'h08, 1'b1, E_BST_ON);
        readback(MR_BOOST, 8'h08);
        boost_time(8'h00, 1'b0, E_BST_OFF);
        pair(CMD_MRR, CMD_MRR, TMRR);
        pair(CMD_MRR, CMD_RD, TMRR);
        pair(CMD_MRR, CMD_WR, E_MRR_WR);
        pair(CMD_MRR, CMD_MWRA, E_MRR_WRO, 1'b1);
        pair(CMD_MRR, CMD_MRW, E_MRR_MRW);
        pair(CMD_WR, CMD_MRR, E_WR_MRR);
        pair(CMD_MWRA, CMD_MRR, E_WR_MRR);
        pair(CMD_PDX, CMD_MRR, E_PDX_MRR);
        pair(CMD_RD, CMD_MRW, E_RD_MRW);
        pair(CMD_RDFIFO, CMD_MRW, E_RD_MRW);
        pair(CMD_RDCAL, CMD_MRW, E_RD_MRW);
        pair(CMD_RDA, CMD_MRW, E_RDA_MRW);
        pair(CMD_WR, CMD_MRW, E_WR_MRW);
        pair(CMD_MWR, CMD_MRW, E_WR_MRW);
        pair(CMD_WRFIFO, CMD_MRW, E_WR_MRW);
        pair(CMD_WRA, CMD_MRW, E_WRA_MRW);
        pair(CMD_MWRA, CMD_MRW, E_WRA_MRW);
        pair(CMD_MRW, CMD_MRW, TMRW);
        pair(CMD_MRW, CMD_MRR, REGWRITE_TO_CMD_DELAY);
        pair(CMD_MRW, CMD_RD, REGWRITE_TO_CMD_DELAY);
        pair(CMD_MRW, CMD_WRA, REGWRITE_TO_CMD_DELAY);
        pair(CMD_MRW, CMD_ACT, E_BST_ON, 1'b0, MR_BOOST, 8'h08);
        pair(CMD_MRW, CMD_PRE, E_BST_OFF, 1'b0, MR_BOOST, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire

/* testbench/mrat_chk.sv */
// Link checker: command spacing, boost quiet time and readback burst
`timescale 1ns/1ps
`default_nettype none
module mrat_chk (
    input wire logic                     clock,
    input wire logic                     rstn,
    input wire mrat_pkg::mrat_cmd_t      cmd,
    input wire logic [mrat_pkg::MA_W-1:0]   ma,
    input wire logic [mrat_pkg::DATA_W-1:0] op,
    input wire logic [mrat_pkg::DATA_W-1:0] dq,
    input wire logic                     dq_oe
);
    import mrat_pkg::*;
    import mrat_tb_pkg::*;
    // Cycles since each class, saturating
    logic [5:0] hit;
    logic [7:0] since_r [6];
    assign hit[0] = (cmd == CMD_MRR);
    assign hit[1] = (cmd == CMD_MRW);
    assign hit[2] = cmd inside {CMD_RD, CMD_RDA, CMD_RDFIFO, CMD_RDCAL};
    assign hit[3] = cmd inside {CMD_WR, CMD_MWR, CMD_WRFIFO};
    assign hit[4] = cmd inside {CMD_WRA, CMD_MWRA};
    assign hit[5] = (cmd == CMD_PDX);
    always_ff @(posedge clock or negedge rstn) begin
        for (int k = 0; k < 6; k++) begin
            if (!rstn) since_r[k] <= 8'hFF;
            else if (hit[k]) since_r[k] <= 8'h01;
            else if (since_r[k] != 8'hFF) since_r[k] <= since_r[k] + 8'h01;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_mrr_read_gap: assert property (cmd inside {CMD_MRR, CMD_RD, CMD_RDA} |-> since_r[0] >= TMRR)
        else $error("MRR to read gap");
    a_mrr_write_gap: assert property (hit[3] || hit[4] |-> since_r[0] >= E_MRR_WMN)
        else $error("MRR to write gap");
    a_mrr_mrw_gap: assert property (hit[1] |-> since_r[0] >= E_MRR_MRW)
        else $error("MRR to MRW gap");
    a_write_mrr_gap: assert property (hit[0] |-> since_r[3] >= E_WR_MRR && since_r[4] >= E_WR_MRR)
        else $error("write to MRR gap");
    a_pdx_mrr_gap: assert property (hit[0] |-> since_r[5] >= E_PDX_MRR)
        else $error("PDX to MRR gap");
    a_read_mrw_gap: assert property (hit[1] |-> since_r[2] >= E_RD_MRW)
        else $error("read to MRW gap");
    a_write_mrw_gap: assert property (hit[1] |-> since_r[3] >= E_WR_MRW && since_r[4] >= E_WRA_MRW)
        else $error("write to MRW gap");
    a_mrw_period: assert property (hit[1] |-> since_r[1] >= TMRW)
        else $error("MRW period");
    a_mrw_cmd_gap: assert property (hit[0] || hit[2] || hit[3] || hit[4] |-> since_r[1] >= REGWRITE_TO_CMD_DELAY)
        else $error("MRW to command gap");
    a_boost_on_quiet: assert property (hit[1] && ma == MR_BOOST && op[BOOST_BIT]
        |=> (cmd == CMD_DES) [*8] ##1 cmd == CMD_DES) else $error("boost on settle");
    a_boost_off_quiet: assert property (hit[1] && ma == MR_BOOST && !op[BOOST_BIT]
        |=> (cmd == CMD_DES) [*4]) else $error("boost off settle");
    a_burst_window: assert property (hit[0] |-> ##15 dq_oe [*8])
        else $error("burst short");
    a_burst_origin: assert property ($rose(dq_oe) |-> $past(cmd, 15) == CMD_MRR)
        else $error("stray burst");
    a_burst_repeat: assert property ($rose(dq_oe) |=> dq == $past(dq) ##1 (dq == 8'h00) [*6])
        else $error("burst data");
endmodule
`default_nettype wire

/* testbench/mrat_tb_pkg.sv */
// Expected command spacings worked out from the timing figures
`default_nettype none
package mrat_tb_pkg;
    import mrat_pkg::*;
    localparam int DQ_C      = (DQSCK_MAX_PS + CLK_PS - 1) / CLK_PS;
    localparam int PST_C     = RPST_PS / CLK_PS;
    localparam int RU75_C    = (GAP_PS + CLK_PS - 1) / CLK_PS;
    localparam int G8_C      = (RU75_C > GAP_MIN_NCK) ? RU75_C : GAP_MIN_NCK;
    localparam int E_MRR_WR  = RL + DQ_C + HALF_BL - WL + WPRE + PST_C;
    localparam int E_MRR_WRO = RL + DQ_C + HALF_BL - TERMINATION_ON_LATENCY - ODTON_MIN_PS / CLK_PS + PST_C + 1;
    localparam int E_MRR_MRW = RL + DQ_C + HALF_BL + 3;
    localparam int E_WR_MRR  = WL + 1 + HALF_BL + (WTR_PS + CLK_PS - 1) / CLK_PS;
    localparam int E_PDX_MRR = TXP + PD_EXIT_READBACK_WAIT;
    localparam int E_RD_MRW  = RL + HALF_BL + DQ_C + PST_C + G8_C;
    localparam int E_RDA_MRW = E_RD_MRW + READ_TO_PRECHARGE_CYCLES - 8;
    localparam int E_WR_MRW  = WL + 1 + HALF_BL + G8_C;
    localparam int E_WRA_MRW = E_WR_MRW + WRITE_RECOVERY_CYCLES;
    localparam int E_BST_ON  = (BOOST_ON_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int E_BST_OFF = (BOOST_OFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // Floor of both termination cases, odt_enable is not visible on the link
    localparam int E_MRR_WMN = (E_MRR_WR < E_MRR_WRO) ? E_MRR_WR : E_MRR_WRO;
endpackage
`default_nettype wire
